// File: common/bitshift_pkg.sv
package bitshift_pkg;

	// ==========================================================
	// widths and reset values
	localparam int DATA_W = 32;
	localparam int AMT_W = 5;
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;
	localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
	localparam logic [31:0] ONE_WORD = 32'h0000_0001;

	// ==========================================================
	// operations carried by this unit
	typedef enum logic [2:0] {
		OP_SETBIT,
		OP_SHLO,
		OP_SHRO,
		OP_SHLI,
		OP_SHRI,
		OP_SHRDI
	} op_t;

endpackage

// File: verilog/right_shifter.sv
`timescale 1ns/10ps
module right_shifter
(
	input  wire logic [31:0] data,
	input  wire logic [4:0]  amt,
	input  wire logic        fill,
	output logic      [31:0] shifted
);

	// ==========================================================
	// five-stage barrel, stage k moves by 2**k
	logic [31:0] stage [0:5];

	assign stage[0] = data;

	genvar k;
	generate
		for (k = 0; k < 5; k++)
		begin : g_stage
			assign stage[k + 1] = amt[k] ?
				{{(2 ** k){fill}}, stage[k][31:(2 ** k)]} : stage[k];
		end
	endgenerate

	assign shifted = stage[5];

endmodule

// File: verilog/bit_set_and_shift_unit.sv
`timescale 1ns/10ps
// What this block does
// - setbit ors in bit at bitpos mod 32
// - shifts use len operand, result written back
// - shifts equal multiply or divide by 2^len
// - logical left: zero when count 32 up
// - logical right: zero when count 32 up
// - arithmetic right floors, saturates to 0/-1
// - dividing right shift rounds toward zero
// - report integer overflow and invalid-operation faults
module bit_set_and_shift_unit
(
	input  wire logic                clk,
	input  wire logic                rst_n,
	input  wire logic                op_valid,
	input  wire bitshift_pkg::op_t   op_code,
	input  wire logic [31:0]         len_in,
	input  wire logic [31:0]         src_in,
	output logic      [31:0]         result_reg,
	output logic                     result_valid_reg,
	output logic                     fault_overflow_reg,
	output logic                     fault_bad_op_reg
);

	// ==========================================================
	// operand decode
	logic        len_big;
	logic [4:0]  amt;
	logic        src_neg;
	logic [31:0] shl_val;
	logic [31:0] shl_back;
	logic [31:0] shr_log;
	logic [31:0] shr_ari;
	logic [31:0] div_bias;
	logic [31:0] div_src;
	logic [31:0] shr_div;
	logic [31:0] result_next;
	logic        overflow_next;
	logic        bad_op_next;

	// only the low five bits give the distance; any higher bit means 32 or more
	assign len_big = |len_in[31:5];
	assign amt = len_in[4:0];
	assign src_neg = src_in[31];
	assign shl_val = src_in << amt;
	assign shl_back = 32'($signed(shl_val) >>> amt);

	// ==========================================================
	// right shifters
	right_shifter u_shr_log
	(
		.data    (src_in),
		.amt     (amt),
		.fill    (1'b0),
		.shifted (shr_log)
	);

	right_shifter u_shr_ari
	(
		.data    (src_in),
		.amt     (amt),
		.fill    (src_neg),
		.shifted (shr_ari)
	);

	// rounding toward zero
	// a negative source gets 2^len-1 added first; it cannot wrap since src < 0
	assign div_bias = src_neg ? ((bitshift_pkg::ONE_WORD << amt) - bitshift_pkg::ONE_WORD) : 32'h0000_0000;
	assign div_src = src_in + div_bias;

	right_shifter u_shr_div
	(
		.data    (div_src),
		.amt     (amt),
		.fill    (div_src[31]),
		.shifted (shr_div)
	);

	// ==========================================================
	// result selection
	always_comb
	begin
		result_next = bitshift_pkg::RESULT_RST;
		overflow_next = 1'b0;
		bad_op_next = 1'b0;
		case (op_code)
			bitshift_pkg::OP_SETBIT:
			begin
				result_next = src_in | (bitshift_pkg::ONE_WORD << amt);
			end
			bitshift_pkg::OP_SHLO:
			begin
				result_next = len_big ? 32'h0000_0000 : shl_val;
			end
			bitshift_pkg::OP_SHRO:
			begin
				result_next = len_big ? 32'h0000_0000 : shr_log;
			end
			bitshift_pkg::OP_SHLI:
			begin
				result_next = len_big ? 32'h0000_0000 : shl_val;
				overflow_next = len_big ? (src_in != 32'h0000_0000) : (shl_back != src_in);
			end
			bitshift_pkg::OP_SHRI:
			begin
				if (len_big)
					result_next = src_neg ? bitshift_pkg::ALL_ONES : 32'h0000_0000;
				else
					result_next = shr_ari;
			end
			bitshift_pkg::OP_SHRDI:
			begin
				// truncating divide; any negative quotient magnitude below one is zero
				result_next = len_big ? 32'h0000_0000 : shr_div;
			end
			default:
			begin
				bad_op_next = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// result register, written only on an issued operation
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			result_reg <= bitshift_pkg::RESULT_RST;
		else if (op_valid)
			result_reg <= result_next;
	end

	// ==========================================================
	// completion and fault pulses, one cycle each
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			result_valid_reg <= 1'b0;
			fault_overflow_reg <= 1'b0;
			fault_bad_op_reg <= 1'b0;
		end
		else
		begin
			result_valid_reg <= op_valid;
			fault_overflow_reg <= op_valid & overflow_next;
			fault_bad_op_reg <= op_valid & bad_op_next;
		end
	end

	// ==========================================================
	// checks
	setbit_result_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SETBIT |=>
		result_reg == ($past(src_in) | (32'h0000_0001 << $past(amt))))
		else $error("setbit result wrong");

	shlo_saturate_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHLO && len_big |=> result_reg == 32'h0000_0000)
		else $error("shlo large count not zero");

	shro_divide_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHRO && !len_big |=>
		result_reg == ($past(src_in) >> $past(amt)))
		else $error("shro result wrong");

	shri_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHRI |=>
		result_reg == ($past(len_big) ? {32{$past(src_neg)}} : 32'($signed($past(src_in)) >>> $past(amt))))
		else $error("shri result wrong");

	shrdi_trunc_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHRDI && !len_big |=>
		$signed(result_reg) == 32'($signed({{32{$past(src_neg)}}, $past(src_in)}) / (64'sh1 << $past(amt))))
		else $error("shrdi quotient wrong");

	shli_multiply_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHLI && !len_big |=>
		result_reg == 32'(64'($past(src_in)) * (64'h1 << $past(amt))))
		else $error("shli product wrong");

	shli_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHLI && len_big && src_in != 32'h0000_0000 |=>
		fault_overflow_reg ##1 !fault_overflow_reg || $past(op_valid))
		else $error("shli overflow missed");

	no_overflow_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code != bitshift_pkg::OP_SHLI || !op_valid |=> !fault_overflow_reg)
		else $error("spurious overflow fault");

	valid_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid |=> result_valid_reg && result_reg == $past(result_next))
		else $error("result not written back");

	// overflow reference built apart from shl_back, so a broken shift-back compare is caught
	logic [63:0] shli_wide;
	logic        shli_lost;

	assign shli_wide = {{32{src_neg}}, src_in} << amt;
	assign shli_lost = !((&shli_wide[63:31]) || !(|shli_wide[63:31]));

	shli_lost_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code == bitshift_pkg::OP_SHLI && !len_big |=> fault_overflow_reg == $past(shli_lost))
		else $error("shli overflow flag wrong");

	bad_op_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_valid && op_code > bitshift_pkg::OP_SHRDI |=> fault_bad_op_reg && result_reg == 32'h0000_0000)
		else $error("unknown operation not faulted");

	// junk operands between issues must never reach the outputs
	idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		!op_valid |=> !result_valid_reg && !fault_overflow_reg && !fault_bad_op_reg && $stable(result_reg))
		else $error("output changed without an issue");

endmodule

// File: sim/issue_model.sv
`timescale 1ns/10ps
// ==========================================================
// issue side: operands are junk between issues
module issue_model
(
	input  wire logic              req,
	input  wire bitshift_pkg::op_t op_req,
	input  wire logic [31:0]       len_req,
	input  wire logic [31:0]       src_req,
	output logic                   op_valid,
	output bitshift_pkg::op_t      op_code,
	output logic [31:0]            len_in,
	output logic [31:0]            src_in
);
	// inverted when idle so a unit that latches late is caught
	always_comb
	begin
		op_valid = req;
		op_code = op_req;
		len_in = req ? len_req : ~len_req;
		src_in = req ? src_req : ~src_req;
	end
endmodule

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic              clk;
	logic              rst_n;
	logic              req;
	logic              op_valid;
	logic              vld;
	logic              ovf;
	logic              bad;
	bitshift_pkg::op_t op_req;
	bitshift_pkg::op_t op_code;
	logic [31:0]       len_req;
	logic [31:0]       src_req;
	logic [31:0]       len_in;
	logic [31:0]       src_in;
	logic [31:0]       res;
	int                failures = 0;
	int                n_compared = 0;
	logic [31:0]       u_lens[4] = '{32'h0, 32'h1f, 32'h20, 32'hffff_ffff};

	issue_model u_iss (.req(req), .op_req(op_req), .len_req(len_req), .src_req(src_req),
		.op_valid(op_valid), .op_code(op_code), .len_in(len_in), .src_in(src_in));
	bit_set_and_shift_unit u_dut (.clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
		.len_in(len_in), .src_in(src_in), .result_reg(res), .result_valid_reg(vld),
		.fault_overflow_reg(ovf), .fault_bad_op_reg(bad));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic check(string what, logic [33:0] seen, logic [33:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// ==========================================================
	// expected {bad, overflow, result}
	function automatic logic [33:0] model(bitshift_pkg::op_t op, logic [31:0] len, logic [31:0] src);
		logic [31:0] r;
		logic        big;
		logic        lost;
		longint      s;
		longint      q;
		longint      a;
		longint      p;
		big = len > 31;
		s = signed'(src);
		// signed math kept in 64 bits so no unsigned context can turn it logical
		q = s / (longint'(1) << len[4:0]);
		a = s >>> len[4:0];
		p = s * (longint'(1) << len[4:0]);
		lost = big ? |src : (longint'(signed'(p[31:0])) != p);
		case (op)
			bitshift_pkg::OP_SETBIT: r = src | (32'h1 << len[4:0]);
			bitshift_pkg::OP_SHLO, bitshift_pkg::OP_SHLI: r = big ? 32'h0 : src << len;
			bitshift_pkg::OP_SHRO: r = big ? 32'h0 : src >> len;
			bitshift_pkg::OP_SHRI: r = big ? {32{src[31]}} : a[31:0];
			bitshift_pkg::OP_SHRDI: r = big ? 32'h0 : q[31:0];
			default: return {2'b10, 32'h0};
		endcase
		if (op != bitshift_pkg::OP_SHLI)
			return {2'b00, r};
		return {1'b0, lost, r};
	endfunction

	task automatic run(bitshift_pkg::op_t op, logic [31:0] len, logic [31:0] src);
		logic [33:0] e;
		e = model(op, len, src);
		@(posedge clk);
		req <= 1'b1;
		op_req <= op;
		len_req <= len;
		src_req <= src;
		@(posedge clk);
		req <= 1'b0;
		#1;
		check("valid", {33'h0, vld}, 34'h1);
		check("result", {bad, ovf, res}, e);
		@(posedge clk);
		#1;
		check("pulse", {31'h0, vld, ovf, bad}, 34'h0);
	endtask

	task automatic t_setbit();
		run(bitshift_pkg::OP_SETBIT, 32'h2f, 32'h0000_0100);
		run(bitshift_pkg::OP_SETBIT, 32'h1f, 32'h0);
		$display("setbit done");
	endtask

	task automatic t_logical();
		foreach (u_lens[i])
		begin
			run(bitshift_pkg::OP_SHLO, u_lens[i], 32'h8000_0001);
			run(bitshift_pkg::OP_SHRO, u_lens[i], 32'h8000_0001);
		end
		$display("logical done");
	endtask

	task automatic t_arith();
		run(bitshift_pkg::OP_SHRI, 32'h4, 32'hffff_fff1);
		run(bitshift_pkg::OP_SHRI, 32'h28, 32'h8000_0000);
		run(bitshift_pkg::OP_SHRI, 32'h28, 32'h7fff_ffff);
		run(bitshift_pkg::OP_SHRDI, 32'h1, 32'hffff_fff9);
		run(bitshift_pkg::OP_SHRDI, 32'h1f, 32'h8000_0001);
		run(bitshift_pkg::OP_SHRDI, 32'h20, 32'h8000_0000);
		$display("arith done");
	endtask

	task automatic t_fault();
		run(bitshift_pkg::OP_SHLI, 32'hd, 32'h0000_0003);
		run(bitshift_pkg::OP_SHLI, 32'h1, 32'h4000_0000);
		run(bitshift_pkg::OP_SHLI, 32'h4, 32'hf800_0000);
		run(bitshift_pkg::OP_SHLI, 32'h21, 32'h1);
		run(bitshift_pkg::OP_SHLI, 32'h40, 32'h0);
		run(bitshift_pkg::op_t'(3'h6), 32'h1, 32'h1);
		run(bitshift_pkg::op_t'(3'h7), 32'h1, 32'h1);
		$display("fault done");
	endtask

	// reset mid-run with an overflowing issue pending, then take it on the first free edge
	task automatic t_reset();
		run(bitshift_pkg::OP_SETBIT, 32'h0, 32'h0000_00f0);
		@(posedge clk);
		rst_n <= 1'b0;
		req <= 1'b1;
		op_req <= bitshift_pkg::OP_SHLI;
		len_req <= 32'h21;
		src_req <= 32'h1;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		check("reset flags", {31'h0, vld, ovf, bad}, 34'h0);
		check("reset result", {2'h0, res}, 34'h0);
		@(posedge clk);
		req <= 1'b0;
		#1;
		check("valid after reset", {33'h0, vld}, 34'h1);
		check("first after reset", {bad, ovf, res}, 34'h1_0000_0000);
		$display("reset done");
	endtask

	task automatic final_report();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		req = 1'b0;
		op_req = bitshift_pkg::OP_SETBIT;
		len_req = 32'h0;
		src_req = 32'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_setbit();
		t_logical();
		t_arith();
		t_fault();
		t_reset();
		final_report();
	end
endmodule
